/* File: src/attr_table_regs.vh */
// Purpose: Constants for the page attribute table block.
// Assumes: Machine-specific register access by index, 64-bit data.
// Notes: Default table is write-back, write-through, uncached-overridable, uncacheable, twice.
`ifndef ATTR_TABLE_REGS_VH
`define ATTR_TABLE_REGS_VH
`define ATTR_TABLE_ADDR 32'h0000_0277
`define FIELD_COUNT 8
`define FIELD_W 8
`define TYPE_W 3
`define TYPE_UNCACHEABLE 3'h0
`define TYPE_WRITE_COMBINING 3'h1
`define TYPE_WRITE_THROUGH 3'h4
`define TYPE_WRITE_PROTECT 3'h5
`define TYPE_WRITE_BACK 3'h6
`define TYPE_UNCACHED_OVERRIDABLE 3'h7
`define ATTR_TABLE_RESET 64'h0007_0406_0007_0406
`define IDENT_LEAF_FEATURES 32'h0000_0001
`define FEATURE_ATTR_BIT 16
`define SELF_SNOOP_BIT 27
`define LOW_REGION_LIMIT 32'h0010_0000
`define SMALL_PAGE_SHIFT 12
`endif

/* File: src/attr_table.v */
// Purpose: Page attribute table register, memory type lookup and feature report.
// Assumes: Register accesses are single-cycle requests from privileged microcode.
// Notes: Soft reset keeps table; only hard reset reloads defaults.
// Behaviour
// - No cross-processor range-register consistency hardware
// - Range types at 4K granularity, cached per entry
// - Conflicting low large page split into 4K
// - Feature query leaf 1 reports bit 16
// - No enable; lookup always when paging on
// - Table is 64-bit register at 277H
// - Eight byte fields, three-bit type each
// - Decode legal codes, others reserved
// - Reserved code write raises protection fault
// - Index is table bit, cache-disable, write-through
// - Defaults on hard reset, kept on soft
`timescale 1ns/100ps
`default_nettype none
`include "attr_table_regs.vh"
module attr_table (
  // Clock and resets
  input wire clock,
  input wire rst_n,
  input wire softReset,
  // Machine-specific register access
  input wire regWrite,
  input wire regRead,
  input wire [31:0] regAddr,
  input wire [63:0] regWrData,
  output reg [63:0] regRdData,
  output reg regRdValid,
  output reg protectionFault,
  // Identification query
  input wire identQuery,
  input wire [31:0] queryLeafReg,
  output reg [31:0] featureResultReg,
  // Page lookup
  input wire pagingOn,
  input wire lookupValid,
  input wire pageAttrBit,
  input wire pageCacheDisable,
  input wire pageWriteThrough,
  input wire largePage,
  input wire [31:0] pageBase,
  input wire [2:0] rangeType,
  input wire fixedRangeConflict,
  output reg [2:0] pageType,
  output reg pageTypeValid,
  output reg splitSmallPages
);
  localparam [63:0] RESET_TABLE = `ATTR_TABLE_RESET;

  // Stored type codes, one per field, and the full word rebuilt from them
  wire [2:0] fieldType [0:`FIELD_COUNT-1];
  wire [63:0] tableView;
  wire [`FIELD_COUNT-1:0] fieldLegal;
  wire tableHit;
  wire allLegal;
  wire writeAccept;
  wire writeRefuse;
  wire readAccept;
  wire lookupTaken;
  wire [2:0] index;
  wire [2:0] selType;
  wire lowOverlap;
  wire splitNeeded;
  wire [31:0] featureWord;

  // Next values of the registered outputs
  reg [63:0] rdData_d;
  reg rdValid_d;
  reg fault_d;
  reg [31:0] feature_d;
  reg [2:0] pageType_d;
  reg typeValid_d;
  reg split_d;

  genvar g;
  generate
    for (g = 0; g < `FIELD_COUNT; g = g + 1) begin : entry
      wire [7:0] wrByte;
      reg [2:0] type_q;
      reg [2:0] type_d;
      assign wrByte = regWrData[g*`FIELD_W +: `FIELD_W];
      // Any high bit set, or codes 2 and 3, makes the byte illegal
      assign fieldLegal[g] = (wrByte[7:3] == 5'h00) && (wrByte[2:1] != 2'h1);
      always @* begin
        type_d = type_q;
        if (writeAccept) begin
          type_d = wrByte[2:0];
        end
      end
      // Hard reset reloads the default; soft reset leaves the field alone
      always @(posedge clock) begin
        if (!rst_n) begin
          type_q <= RESET_TABLE[g*`FIELD_W +: `TYPE_W];
        end else begin
          type_q <= type_d;
        end
      end
      assign fieldType[g] = type_q;
      // Only legal bytes are stored, so reserved bits read back as zero
      assign tableView[g*`FIELD_W +: `FIELD_W] = {5'h00, type_q};
    end
  endgenerate

  assign tableHit = (regAddr == `ATTR_TABLE_ADDR);
  assign allLegal = &fieldLegal;
  // Whole word taken or refused; a partial update would split the table
  assign writeAccept = regWrite && tableHit && allLegal;
  assign writeRefuse = regWrite && tableHit && !allLegal;
  assign readAccept = regRead && tableHit;
  // No enable bit exists; paging alone gates the lookup
  assign lookupTaken = lookupValid && pagingOn;
  assign index = {pageAttrBit, pageCacheDisable, pageWriteThrough};
  assign selType = fieldType[index];
  assign lowOverlap = largePage && (pageBase < `LOW_REGION_LIMIT);
  // Range type is per 4K granule, so a conflicting low large page is split
  assign splitNeeded = lowOverlap && fixedRangeConflict;
  assign featureWord = (queryLeafReg == `IDENT_LEAF_FEATURES) ?
    (32'h1 << `FEATURE_ATTR_BIT) : 32'h0;

  always @* begin
    rdValid_d = readAccept;
    rdData_d = 64'h0;
    if (readAccept) begin
      rdData_d = tableView;
    end
  end

  always @* begin
    fault_d = writeRefuse;
  end

  always @* begin
    feature_d = featureResultReg;
    if (identQuery) begin
      feature_d = featureWord;
    end
  end

  always @* begin
    typeValid_d = lookupTaken;
    pageType_d = pageType;
    split_d = splitSmallPages;
    if (lookupTaken) begin
      pageType_d = selType;
      split_d = splitNeeded;
    end
  end

  // Read answer stands for one cycle only
  always @(posedge clock) begin
    if (!rst_n || softReset) begin
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= rdValid_d;
    end
  end

  always @(posedge clock) begin
    if (!rst_n || softReset) begin
      regRdData <= 64'h0;
    end else begin
      regRdData <= rdData_d;
    end
  end

  always @(posedge clock) begin
    if (!rst_n || softReset) begin
      protectionFault <= 1'b0;
    end else begin
      protectionFault <= fault_d;
    end
  end

  // Feature word holds until the next query
  always @(posedge clock) begin
    if (!rst_n || softReset) begin
      featureResultReg <= 32'h0;
    end else begin
      featureResultReg <= feature_d;
    end
  end

  always @(posedge clock) begin
    if (!rst_n || softReset) begin
      pageTypeValid <= 1'b0;
    end else begin
      pageTypeValid <= typeValid_d;
    end
  end

  // Type stands until the next lookup, like a cache entry
  always @(posedge clock) begin
    if (!rst_n || softReset) begin
      pageType <= 3'h0;
    end else begin
      pageType <= pageType_d;
    end
  end

  always @(posedge clock) begin
    if (!rst_n || softReset) begin
      splitSmallPages <= 1'b0;
    end else begin
      splitSmallPages <= split_d;
    end
  end

  // No consistency logic across processors exists here
  // rangeType is resolved outside; kept for combining in the cache entry
  wire unusedRange = ^rangeType;
endmodule
`default_nettype wire

/* File: dv/attr_table_assertions.sv */
// Purpose: port checks. Assumes: one clock. Notes: soft reset drops answers.
`timescale 1ns/100ps
`default_nettype none
module attr_table_chk(input wire clock,rst_n,softReset,regWrite,regRead,identQuery,lookupValid,
  pagingOn,regRdValid,protectionFault,pageTypeValid,input wire [31:0] regAddr,queryLeafReg,
  featureResultReg,input wire [63:0] regWrData,regRdData);
  default clocking @(posedge clock);endclocking
  default disable iff(!rst_n||softReset);
  wire h=regAddr==32'h277;
  property p_rd;regRead&&h|=>regRdValid;endproperty
  a_rd:assert property(p_rd)else $error("rd");
  property p_ms;regRead&&!h|=>!regRdValid&&regRdData==64'h0;endproperty
  a_ms:assert property(p_ms)else $error("ms");
  property p_gp;regWrite&&h&&regWrData[2:1]==2'h1|=>protectionFault;endproperty
  a_gp:assert property(p_gp)else $error("gp");
  property p_nf;!regWrite|=>!protectionFault;endproperty
  a_nf:assert property(p_nf)else $error("nf");
  property p_wb;regWrite&&h ##1 !protectionFault&&!regWrite ##1 regRead&&h
    |=>regRdData==$past(regWrData,3);
  endproperty
  a_wb:assert property(p_wb)else $error("wb");
  property p_id;identQuery|=>featureResultReg[16]==($past(queryLeafReg)==32'h1);endproperty
  a_id:assert property(p_id)else $error("id");
  property p_st;!identQuery|=>$stable(featureResultReg);endproperty
  a_st:assert property(p_st)else $error("st");
  property p_lk;lookupValid|=>pageTypeValid==$past(pagingOn);endproperty
  a_lk:assert property(p_lk)else $error("lk");
endmodule
bind attr_table attr_table_chk attr_table_chk_inst(.*);
`default_nettype wire

/* File: dv/sw_agent.sv */
// Purpose: software model. Assumes: called after an edge. Notes: idle cycle after each access.
`timescale 1ns/100ps
`default_nettype none
module sw_agent(input wire clock,output logic regWrite=0,regRead=0,
  output logic [31:0] regAddr=0,output logic [63:0] regWrData=0);
  task acc(bit w,logic [31:0] a,logic [63:0] d);
    {regWrite,regRead,regAddr,regWrData}<={w,!w,a,d};@(posedge clock);
    {regWrite,regRead}<=2'h0;@(posedge clock);endtask
  // Processor-side state walked by the update procedure
  logic intrOn=1,cacheDisable=0,noWritethrough=0,globalPages=1,rangeOn=1;
  task boot(logic [63:0] d);rangeOn=0;acc(1,32'h277,d);rangeOn=1;endtask
  // Only the table write reaches the block; the rest is local state
  task update(logic [63:0] d);intrOn=0;
    cacheDisable=1;noWritethrough=0;
    @(posedge clock);globalPages=0;
    rangeOn=0;
    if(!rangeOn&&cacheDisable&&!noWritethrough&&!intrOn)acc(1,32'h277,d);
    rangeOn=1;@(posedge clock);
    {cacheDisable,noWritethrough,globalPages,intrOn}=4'h3;endtask
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// Purpose: bench. Assumes: sw_agent owns register bus. Notes: large page at 0.
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam logic [63:0] D=64'h7040600070406,T=64'h706050401000706;
  logic clock=0,rst_n=0,softReset=0,identQuery=0,pagingOn=1,lookupValid=0,pageAttrBit=0,
    pageCacheDisable=0,pageWriteThrough=0,fixedRangeConflict=0,regWrite,regRead,regRdValid,
    protectionFault,pageTypeValid,splitSmallPages,largePage=1;
  logic [2:0] pageType;
  logic [31:0] queryLeafReg=0,pageBase=0,regAddr,featureResultReg;
  logic [63:0] regWrData,regRdData;
  int errors=0,checksDone=0;
  attr_table attr_table_inst(.*,.rangeType(3'h0));
  sw_agent sw_agent_inst(.*);
  initial forever #5 clock=~clock;
  task c(string n,logic [63:0] e,g);checksDone++;
    if(g!==e)begin errors++;$display("MISMATCH %s exp %h got %h",n,e,g);end endtask
  task t;@(posedge clock);endtask
  task lk(logic [3:0] i);{fixedRangeConflict,pageAttrBit,pageCacheDisable,pageWriteThrough}<=i;
    lookupValid<=1;t;lookupValid<=0;t;c("valid",pagingOn,pageTypeValid);endtask
  task rd(logic [63:0] e);sw_agent_inst.acc(0,32'h277,0);c("table",e,regRdData);
    c("rdvalid",1,regRdValid);endtask
  task wr(logic [31:0] a,logic [63:0] d,bit f);sw_agent_inst.acc(1,a,d);
    c("fault",f,protectionFault);endtask
  task s_map;rd(D);
    sw_agent_inst.acc(0,32'h276,0);c("miss",0,regRdData);c("missvalid",0,regRdValid);
    sw_agent_inst.boot(T);c("fault",0,protectionFault);rd(T);
    for(int i=0;i<16;i++)begin lk(i);c("type",T[8*i[2:0]+:3],pageType);
      c("split",i>7,splitSmallPages);end endtask
  task s_bad;wr(32'h277,T^64'h104,1);wr(32'h277,T|64'h8,1);
    wr(32'h276,D,0);rd(T);endtask
  task s_rst;softReset<=1;t;softReset<=0;t;rd(T);
    c("softtype",0,pageType);c("softsplit",0,splitSmallPages);
    rst_n<=0;t;rst_n<=1;t;rd(D);
    pageBase<=32'h0010_0000;lk(4'hb);c("type",0,pageType);c("split",0,splitSmallPages);
    pageBase<=32'h0040_0000;lk(4'h8);c("split",0,splitSmallPages);
    largePage<=0;pageBase<=0;lk(4'h8);c("split",0,splitSmallPages);
    largePage<=1;sw_agent_inst.update(T);rd(T);endtask
  task s_id;for(int l=0;l<3;l++)begin queryLeafReg<=l;identQuery<=1;t;identQuery<=0;t;
      c("feature",l==1,featureResultReg[16]);end
    pagingOn<=0;lk(0);pagingOn<=1;c("valid",0,pageTypeValid);endtask
  task test_done;$display("errors %0d checks %0d",errors,checksDone);
    if(errors==0&&checksDone>0)$display("Result: passed");
    else $display("Result: failed");
    $finish;endtask
  initial begin repeat(8)t;rst_n<=1;t;s_map;s_bad;s_rst;s_id;test_done;end
  initial begin repeat(3000)t;errors++;test_done;end
endmodule
`default_nettype wire
